// ==== include/iat_pkg.sv ====
// Purpose: shared constants for the input alarm threshold register bank
// Assumes: apb with 32-bit data, byte addresses
// Notes: alarm flag and interrupt words sit at chosen offsets
package iat_pkg;
	localparam logic [7:0]  OFS_UPPER      = 8'h24;
	localparam logic [7:0]  OFS_LOWER      = 8'h28;
	localparam logic [7:0]  OFS_FLAGS      = 8'h20;
	localparam logic [7:0]  OFS_IRQ_STATUS = 8'h30;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h34;
	localparam logic [15:0] RST_UPPER      = 16'hffff;
	localparam logic [15:0] RST_LOWER      = 16'h0000;
	localparam logic [7:0]  RST_HYST       = 8'h00;
	localparam int          POS_HYST       = 24;
	localparam int          POS_SUMMARY    = 0;
	localparam int          POS_TRP_HIGH   = 4;
	localparam int          POS_TRP_LOW    = 5;
	localparam int          POS_ACT_HIGH   = 10;
	localparam int          POS_ACT_LOW    = 11;
	localparam int          IRQ_BITS       = 2;
	typedef enum logic [1:0] {
		IAT_IDLE   = 2'b00,
		IAT_ACCESS = 2'b01
	} iat_bus_state_t;
endpackage

// ==== src/iat_window_cmp.sv ====
// Purpose: one-sided limit compare with hysteresis release
// Assumes: unsigned codes, sample valid one cycle
// Notes: state lives in the caller
`timescale 1ns/1ps
`default_nettype none
module iat_window_cmp #(
	parameter int W = 16
) (
	// sample and limit
	input  wire logic [W-1:0] sample,
	input  wire logic [W-1:0] limit,
	input  wire logic [7:0]   hyst,
	input  wire logic         is_upper,
	input  wire logic         active_now,
	// result
	output logic              active_next
);
	logic [W:0] rel;
	always_comb begin
		if (is_upper) begin
			rel = {1'b0, limit} - {{(W-8){1'b0}}, 1'b0, hyst};
			if (sample > limit)
				active_next = 1'b1;
			else if (active_now && ({1'b0, sample} >= rel || rel[W]))
				active_next = 1'b1;
			else
				active_next = 1'b0;
		end else begin
			rel = {1'b0, limit} + {{(W-8){1'b0}}, 1'b0, hyst};
			if (sample < limit)
				active_next = 1'b1;
			else if (active_now && {1'b0, sample} <= rel)
				active_next = 1'b1;
			else
				active_next = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== src/iat_apb_decode.sv ====
// Purpose: apb access decode for the register bank
// Assumes: zero wait states
// Notes: unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
module iat_apb_decode (
	// apb request
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	// decoded strobes
	output logic            wr_upper,
	output logic            wr_lower,
	output logic            wr_status,
	output logic            wr_mask,
	output logic            mapped
);
	logic acc;
	logic [7:0] wa;
	always_comb begin
		acc = psel && penable;
		wa = {paddr[7:2], 2'b00};
		mapped = (wa == iat_pkg::OFS_UPPER) || (wa == iat_pkg::OFS_LOWER)
			|| (wa == iat_pkg::OFS_FLAGS) || (wa == iat_pkg::OFS_IRQ_STATUS)
			|| (wa == iat_pkg::OFS_IRQ_MASK);
		wr_upper  = acc && pwrite && wa == iat_pkg::OFS_UPPER;
		wr_lower  = acc && pwrite && wa == iat_pkg::OFS_LOWER;
		wr_status = acc && pwrite && wa == iat_pkg::OFS_IRQ_STATUS;
		wr_mask   = acc && pwrite && wa == iat_pkg::OFS_IRQ_MASK;
	end
endmodule
`default_nettype wire

// ==== src/iat_regs.sv ====
// Purpose: input alarm limit registers with alarm flags and interrupt
// Assumes: conversion results arrive as a one-cycle valid strobe
// Notes: zero-wait apb slave, byte lanes through pstrb
`timescale 1ns/1ps
`default_nettype none
module iat_regs #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// conversion results
	input  wire logic         sample_valid,
	input  wire logic [W-1:0] sample,
	// alarm outputs
	output logic              alarm_high,
	output logic              alarm_low,
	output logic              irq
);
	typedef struct packed {
		logic [W-1:0] upper;
		logic [W-1:0] lower;
		logic [7:0]   hyst;
		logic         act_high;
		logic         act_low;
		logic         trp_high;
		logic         trp_low;
		logic [1:0]   irq_status;
		logic [1:0]   irq_mask;
		logic [31:0]  rdata;
	} iat_state_t;

	iat_state_t st_reg;
	iat_state_t st_next;
	logic       wr_upper;
	logic       wr_lower;
	logic       wr_status;
	logic       wr_mask;
	logic       mapped;
	logic       high_next;
	logic       low_next;
	logic [31:0] upper_word;
	logic [31:0] lower_word;
	logic [31:0] flag_word;

	iat_apb_decode u_dec (
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.wr_upper  (wr_upper),
		.wr_lower  (wr_lower),
		.wr_status (wr_status),
		.wr_mask   (wr_mask),
		.mapped    (mapped)
	);

	iat_window_cmp #(.W(W)) u_hi (
		.sample      (sample),
		.limit       (st_reg.upper),
		.hyst        (st_reg.hyst),
		.is_upper    (1'b1),
		.active_now  (st_reg.act_high),
		.active_next (high_next)
	);

	iat_window_cmp #(.W(W)) u_lo (
		.sample      (sample),
		.limit       (st_reg.lower),
		.hyst        (st_reg.hyst),
		.is_upper    (1'b0),
		.active_now  (st_reg.act_low),
		.active_next (low_next)
	);

	always_comb begin
		// reserved bytes held at zero by construction
		upper_word = 32'h0000_0000;
		upper_word[31:24] = st_reg.hyst;
		upper_word[W-1:0] = st_reg.upper;
		lower_word = 32'h0000_0000;
		lower_word[W-1:0] = st_reg.lower;
		flag_word = 32'h0000_0000;
		flag_word[iat_pkg::POS_TRP_HIGH] = st_reg.trp_high;
		flag_word[iat_pkg::POS_TRP_LOW]  = st_reg.trp_low;
		flag_word[iat_pkg::POS_ACT_HIGH] = st_reg.act_high;
		flag_word[iat_pkg::POS_ACT_LOW]  = st_reg.act_low;
		flag_word[iat_pkg::POS_SUMMARY]  = st_reg.trp_high | st_reg.trp_low;
	end

	always_comb begin
		st_next = st_reg;
		// byte lanes: lane 0 is the lowest byte address
		for (int b = 0; b < 4; b++) begin
			if (wr_upper && pstrb[b]) begin
				if (b == 3)
					st_next.hyst = pwdata[31:24];
				else if (b < 2)
					st_next.upper[b*8 +: 8] = pwdata[b*8 +: 8];
			end
			if (wr_lower && pstrb[b] && b < 2)
				st_next.lower[b*8 +: 8] = pwdata[b*8 +: 8];
		end
		if (sample_valid) begin
			st_next.act_high = high_next;
			st_next.act_low  = low_next;
		end
		// tripped flags latch until a new result clears the condition
		if (sample_valid) begin
			st_next.trp_high = high_next;
			st_next.trp_low  = low_next;
		end
		if (wr_mask && pstrb[0])
			st_next.irq_mask = pwdata[1:0];
		if (wr_status && pstrb[0])
			st_next.irq_status = st_reg.irq_status & ~pwdata[1:0];
		// set beats clear so a rising alarm is never lost
		if (sample_valid && high_next && !st_reg.act_high)
			st_next.irq_status[0] = 1'b1;
		if (sample_valid && low_next && !st_reg.act_low)
			st_next.irq_status[1] = 1'b1;
		st_next.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case ({paddr[7:2], 2'b00})
				iat_pkg::OFS_UPPER:      st_next.rdata = upper_word;
				iat_pkg::OFS_LOWER:      st_next.rdata = lower_word;
				iat_pkg::OFS_FLAGS:      st_next.rdata = flag_word;
				iat_pkg::OFS_IRQ_STATUS: st_next.rdata = {30'h0, st_reg.irq_status};
				iat_pkg::OFS_IRQ_MASK:   st_next.rdata = {30'h0, st_reg.irq_mask};
				default:                 st_next.rdata = 32'h0000_0000;
			endcase
		end else if (psel && penable) begin
			st_next.rdata = st_reg.rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.upper <= W'(iat_pkg::RST_UPPER);
			st_reg.lower <= W'(iat_pkg::RST_LOWER);
			st_reg.hyst <= iat_pkg::RST_HYST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !mapped;
	assign prdata     = st_reg.rdata;
	assign alarm_high = st_reg.act_high;
	assign alarm_low  = st_reg.act_low;
	assign irq        = |(st_reg.irq_status & st_reg.irq_mask);
endmodule
`default_nettype wire

// ==== sim/iat_regs_props.sv ====
// Purpose: apb and flag checks for the limit register bank
// Assumes: zero-wait slave, word aligned accesses
// Notes: alarm timing is left to the bench
`timescale 1ns/1ps
`default_nettype none
module iat_regs_props (
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// alarm side
	input wire logic        alarm_high
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rd, map;
	assign acc = psel && penable;
	assign rd  = acc && !pwrite;
	// decode ignores the two low address bits, so the check must too
	assign map = {paddr[7:2], 2'b00} inside {iat_pkg::OFS_FLAGS, iat_pkg::OFS_UPPER, iat_pkg::OFS_LOWER,
		iat_pkg::OFS_IRQ_STATUS, iat_pkg::OFS_IRQ_MASK};
	a_ready_tied: assert property (psel |-> pready) else $error("pready low");
	a_err_unmapped: assert property (acc && !map |-> pslverr) else $error("no pslverr");
	a_ok_mapped: assert property (acc && map |-> !pslverr) else $error("bad pslverr");
	a_zero_unmapped: assert property (rd && !map |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_resv_upper: assert property (rd && paddr == iat_pkg::OFS_UPPER |-> prdata[23:16] == 8'h00)
		else $error("upper reserved byte set");
	a_resv_lower: assert property (rd && paddr == iat_pkg::OFS_LOWER |-> prdata[31:16] == 16'h0000)
		else $error("lower reserved half set");
	a_summary_or: assert property (rd && paddr == iat_pkg::OFS_FLAGS |-> prdata[0] == |prdata[5:4])
		else $error("summary bit wrong");
	a_upper_echo: assert property (acc && pwrite && paddr == iat_pkg::OFS_UPPER && pstrb == 4'hf ##1
		psel && !penable && !pwrite && paddr == iat_pkg::OFS_UPPER ##1 acc
		|-> {prdata[31:24], prdata[15:0]} == {$past(pwdata[31:24], 2), $past(pwdata[15:0], 2)})
		else $error("upper readback wrong");
	a_lower_echo: assert property (acc && pwrite && paddr == iat_pkg::OFS_LOWER && pstrb == 4'hf ##1
		psel && !penable && !pwrite && paddr == iat_pkg::OFS_LOWER ##1 acc
		|-> prdata[15:0] == $past(pwdata[15:0], 2)) else $error("lower readback wrong");
	cover property (acc && !map);
	cover property ($rose(alarm_high));
	cover property (rd && paddr == iat_pkg::OFS_FLAGS && prdata[0]);
endmodule
`default_nettype wire

// ==== sim/input_alarm_threshold_regs_bench.sv ====
// Purpose: random and corner checks of the limit register bank
// Assumes: read data and pslverr taken at the access edge
// Notes: hysteresis hold and release checked at the band edge
`timescale 1ns/1ps
`default_nettype none
module input_alarm_threshold_regs_bench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
	logic [7:0]  paddr = 0, a;
	logic [3:0]  pstrb = 0, s;
	logic [31:0] pwdata = 0, prdata, rd, d, up_m, lo_m;
	logic [15:0] sample = 0, u;
	logic        pready, pslverr, alarm_high, alarm_low, irq, err;
	int          n_errors = 0, cmp_count = 0, seed = 88;
	iat_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
		.alarm_high(alarm_high), .alarm_low(alarm_low), .irq(irq));
	initial forever #2 pclk = ~pclk;
	task chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// request stays up after return: caller follows with xfer or idle at once
	task xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] st);
		int k;
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ad, wd, st};
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 8);
		if (pready !== 1'b1) begin
			n_errors++;
			stop_test;
		end
		rd = prdata;
		err = pslverr;
	endtask
	task idle;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task rdc(input logic [7:0] ad, input logic [31:0] e);
		xfer(0, ad, 32'h0000_0000, 4'h0);
		chk(rd, e);
	endtask
	task hit(input logic [15:0] v, input logic hi, want);
		int k;
		{sample, sample_valid} <= {v, 1'b1};
		@(posedge pclk);
		sample_valid <= 0;
		for (k = 0; k < 4 && (hi ? alarm_high : alarm_low) !== want; k++)
			@(negedge pclk);
		chk(hi ? alarm_high : alarm_low, want);
		@(posedge pclk);
	endtask
	function automatic logic [31:0] merge(input logic [31:0] o, wd, input logic [3:0] st);
		for (int b = 0; b < 4; b++)
			if (st[b]) o[8*b +: 8] = wd[8*b +: 8];
		return o;
	endfunction
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rdc(iat_pkg::OFS_UPPER, 32'h0000_ffff);
		rdc(iat_pkg::OFS_LOWER, 32'h0000_0000);
		{up_m, lo_m} = {32'h0000_ffff, 32'h0000_0000};
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			s = (i < 2) ? 4'hf : 4'($random(seed));
			d[25:24] = 2'b00;
			a = i[0] ? iat_pkg::OFS_LOWER : iat_pkg::OFS_UPPER;
			xfer(1, a, d, s);
			if (i[0]) lo_m = merge(lo_m, d, s) & 32'h0000_ffff;
			else up_m = merge(up_m, d, s) & 32'hff00_ffff;
			rdc(a, i[0] ? lo_m : up_m);
		end
		xfer(1, 8'h2c, 32'hffff_ffff, 4'hf);
		chk(err, 1);
		rdc(8'h2c, 32'h0000_0000);
		rdc(iat_pkg::OFS_UPPER, up_m);
		u = 16'h1000 + 16'($random(seed) & 32'h0000_0fff);
		xfer(1, iat_pkg::OFS_UPPER, {16'h0000, u}, 4'hf);
		xfer(1, iat_pkg::OFS_LOWER, 32'h0000_0800, 4'hf);
		idle;
		hit(u + 16'h0001, 1, 1);
		rdc(iat_pkg::OFS_FLAGS, 32'h0000_0411);
		rdc(iat_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		xfer(1, iat_pkg::OFS_IRQ_MASK, 32'h0000_0000, 4'hf);
		idle;
		chk(irq, 0);
		xfer(1, iat_pkg::OFS_IRQ_MASK, 32'h0000_0003, 4'hf);
		idle;
		chk(irq, 1);
		xfer(1, iat_pkg::OFS_IRQ_STATUS, 32'h0000_0001, 4'hf);
		idle;
		chk(irq, 0);
		hit(u - 16'h0001, 1, 0);
		xfer(1, iat_pkg::OFS_UPPER, {8'h10, 8'h00, u}, 4'hf);
		idle;
		hit(u + 16'h0001, 1, 1);
		// band edge still holds, one below it releases
		hit(u - 16'h0010, 1, 1);
		hit(u - 16'h0011, 1, 0);
		hit(16'h07ff, 0, 1);
		rdc(iat_pkg::OFS_FLAGS, 32'h0000_0821);
		rdc(iat_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		idle;
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rdc(iat_pkg::OFS_UPPER, 32'h0000_ffff);
		rdc(iat_pkg::OFS_LOWER, 32'h0000_0000);
		rdc(iat_pkg::OFS_FLAGS, 32'h0000_0000);
		idle;
		chk(irq, 0);
		stop_test;
	end
endmodule
bind iat_regs iat_regs_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_high(alarm_high));
`default_nettype wire
